// file: verilog/lcc_cfg.svh
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH
// Cluster geometry
`define LCC_N_MOD 8
`define LCC_N_REG 16
`define LCC_N_ROW_CLK 6
`define LCC_N_LINE 3
// Register byte offsets
`define LCC_OFF_CLKCFG 8'h00
`define LCC_OFF_MODE 8'h04
`define LCC_OFF_STATUS 8'h08
`define LCC_OFF_WIDE 8'h0C
`define LCC_LUT_BASE_HI 3'h2
// Clock config fields: line k at [4k+3:4k] as {invert, row index}
`define LCC_CLK_LINE_W 4
`define LCC_CLK_AUSE_BIT 12
`define LCC_CLK_ADSEL_LSB 16
// Mode fields
`define LCC_MODE_FB_LSB 16
`define LCC_MODE_ACLR_LSB 24
// Reset values: line0 row 0, line1 row 1, line2 row 1 inverted
`define LCC_RST_CLKCFG 32'h0000_0910
`define LCC_RST_MODE 32'h0000_0000
`define LCC_RST_WIDE 8'h00
`define LCC_RST_MODE2 32'h0000_0000
`define LCC_OFF_MODE2 8'h10
`endif

// file: verilog/lcc_pkg.sv
`default_nettype none
package lcc_pkg;
    // Whole state of the cluster in one vector
    typedef struct packed {
        logic [5:0] rc_meta;
        logic [5:0] rc_sync;
        logic [5:0] rc_prev;
        logic [31:0] clkcfg;
        logic [31:0] mode;
        logic [31:0] mode2;
        logic [7:0] wide;
        logic [7:0][31:0] lut;
        logic [15:0] q;
        logic ack;
        logic [31:0] rdat;
    } lcc_state_t;
endpackage
`default_nettype wire

// file: verilog/lcc_cluster.sv
`timescale 1ns/100ps
`default_nettype none
`include "lcc_cfg.svh"
// Summary of operation
// R1 - Eight logic modules form one cluster
// R2 - Three clocks, enables, clears, loads generated
// R3 - At most two distinct source clocks
// R4 - Each clock line uses its own enable
// R5 - Deasserted enable gates off its clock line
// R6 - Async load in use disables enable zero
// R7 - Preset is async load with data one
// R8 - Controls derive from six row clocks
// R9 - Two registers per module, full control set
// R10 - Controls come from pins or internal logic
// R11 - Async load data from fifth/sixth input
// R12 - Combinational path bypasses the register
// R13 - Register chain feeds adjacent module register
// R14 - Two output sets per module
// R15 - Register output may feed own lookup
// R16 - Registered and unregistered results together
// R17 - Lookup splits in halves or one wide
// R18 - Outputs fan out to neighbouring modules
// R19 - Sync load captures load data on edge
// R20 - Clear beats load, sync only when enabled
// R21 - Rising edge registers, inversion via line
module lcc_cluster #(
    parameter int N_MOD = 8,
    parameter int N_ROW_CLK = 6
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Row clock lines from pins
    input wire logic [5:0] row_clk_i,
    // Cluster controls from local interconnect
    input wire logic [2:0] clk_gate_i,
    input wire logic [1:0] aclr_i,
    input wire logic sclr_i,
    input wire logic aload_i,
    input wire logic sload_i,
    // Module data inputs, 8 per module {f1,e1,f0,e0,d,c,b,a}
    input wire logic [63:0] data_i,
    input wire logic chain_i,
    // Module outputs
    output logic [15:0] route_o,
    output logic [15:0] lut_o,
    output logic [15:0] reg_o,
    output logic chain_o
);

    // R1 cluster size check
    initial begin
        if (N_MOD != `LCC_N_MOD || N_ROW_CLK != `LCC_N_ROW_CLK) begin
            $error("lcc_cluster: geometry must be 8 modules and 6 row clocks");
        end
    end

    // Whole block state and its next value
    lcc_pkg::lcc_state_t s_r;
    lcc_pkg::lcc_state_t s_nxt;

    // Per line and per register helpers
    logic [2:0][2:0] line_idx;
    logic [2:0] line_rise;
    logic [2:0] line_gate;
    logic clk_conflict;
    logic aload_use;
    logic [15:0] lut_v;
    logic [15:0] edge_v;
    logic [15:0] aclr_v;
    logic [15:0] aload_v;
    logic [15:0] adat_v;
    logic [15:0] d_v;
    logic [15:0] q_v;
    logic [15:0] chain_src;
    logic [15:0] bypass;
    logic [31:0] rd_val;
    logic [3:0] lut_addr;
    logic a_eff;
    logic [4:0] r0_i;
    logic [4:0] r1_i;
    logic [1:0] ln;
    logic [7:0] din;

    // Byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // R13 chain source is the previous register in the cluster
    assign chain_src = {s_r.q[14:0], chain_i};
    assign bypass = s_r.mode2[31:16];
    // R6 async load enabled by configuration
    assign aload_use = s_r.clkcfg[`LCC_CLK_AUSE_BIT];

    // R2 three lines with three enables
    // Clock line generation from synchronised row clocks
    always_comb begin
        line_idx = '0;
        line_rise = '0;
        line_gate = '0;
        for (int k = 0; k < `LCC_N_LINE; k++) begin
            // R8 row index above 5 falls back to row 0
            line_idx[k] = s_r.clkcfg[`LCC_CLK_LINE_W*k +: 3];
            if (line_idx[k] > 3'h5) begin
                line_idx[k] = 3'h0;
            end
            // R21 inverted source gives falling edge on its own line
            line_rise[k] = (s_r.rc_sync[line_idx[k]] ^ s_r.clkcfg[`LCC_CLK_LINE_W*k+3])
                & ~(s_r.rc_prev[line_idx[k]] ^ s_r.clkcfg[`LCC_CLK_LINE_W*k+3]);
            // R4 R5 each line gated by its own enable
            line_gate[k] = clk_gate_i[k];
        end
        // R6 enable zero unavailable while async load is used
        if (aload_use) begin
            line_gate[0] = 1'b1;
        end
    end

    // R3 three distinct sources: third line is shut off
    // Dropping line two keeps the cell working; status reports it
    assign clk_conflict = (line_idx[0] != line_idx[1]) && (line_idx[0] != line_idx[2])
        && (line_idx[1] != line_idx[2]);

    // Per register datapath
    always_comb begin
        lut_v = '0;
        edge_v = '0;
        aclr_v = '0;
        aload_v = '0;
        adat_v = '0;
        d_v = '0;
        q_v = s_r.q;
        lut_addr = '0;
        a_eff = 1'b0;
        r0_i = '0;
        r1_i = '0;
        ln = '0;
        din = '0;
        for (int m = 0; m < `LCC_N_MOD; m++) begin
            din = data_i[8*m +: 8];
            ln = s_r.mode[2*m +: 2];
            if (ln == 2'h3) begin
                ln = 2'h0;
            end
            // R9 two registers, one per half
            for (int h = 0; h < 2; h++) begin
                // R15 register output feeds back into own lookup
                a_eff = s_r.mode[`LCC_MODE_FB_LSB+m] ? s_r.q[2*m+h] : din[0];
                lut_addr = {din[3], din[2], din[1], a_eff};
                r0_i = {1'b0, lut_addr};
                r1_i = {1'b1, lut_addr};
                // R17 two halves, or one wide function selected by f0
                if (s_r.wide[m]) begin
                    lut_v[2*m+h] = din[5] ? s_r.lut[m][r1_i] : s_r.lut[m][r0_i];
                end else begin
                    lut_v[2*m+h] = (h == 1) ? s_r.lut[m][r1_i] : s_r.lut[m][r0_i];
                end
                // R11 load data from e or f input of this half
                adat_v[2*m+h] = s_r.clkcfg[`LCC_CLK_ADSEL_LSB+2*m+h] ? din[5+2*h] : din[4+2*h];
                // R4 R5 edge counts only on enabled line
                edge_v[2*m+h] = line_rise[ln] & line_gate[ln] & ~(ln == 2'h2 && clk_conflict);
                // R10 clear and load come from interconnect inputs
                aclr_v[2*m+h] = s_r.mode[`LCC_MODE_ACLR_LSB+m] ? aclr_i[1] : aclr_i[0];
                aload_v[2*m+h] = aload_i & aload_use;
            end
        end
        for (int i = 0; i < `LCC_N_REG; i++) begin
            // R13 chain or lookup result as register data
            d_v[i] = s_r.mode2[i] ? chain_src[i] : lut_v[i];
            // R20 async clear over async load
            if (aclr_v[i]) begin
                q_v[i] = 1'b0;
            // R7 preset is async load with data high
            end else if (aload_v[i]) begin
                q_v[i] = adat_v[i];
            end else if (edge_v[i]) begin
                // R19 R20 sync clear over sync load, on enabled edge
                if (sclr_i) begin
                    q_v[i] = 1'b0;
                end else if (sload_i) begin
                    q_v[i] = adat_v[i];
                end else begin
                    q_v[i] = d_v[i];
                end
            end
        end
    end

    // Read mux; unmapped offsets read zero
    // Status bit 16 flags three distinct sources
    always_comb begin
        rd_val = 32'h0000_0000;
        if (wb_adr_i[7:5] == `LCC_LUT_BASE_HI) begin
            rd_val = s_r.lut[wb_adr_i[4:2]];
        end else begin
            unique case (wb_adr_i)
                `LCC_OFF_CLKCFG: rd_val = s_r.clkcfg;
                `LCC_OFF_MODE: rd_val = s_r.mode;
                `LCC_OFF_STATUS: rd_val = {15'h0000, clk_conflict, s_r.q};
                `LCC_OFF_WIDE: rd_val = {24'h00_0000, s_r.wide};
                `LCC_OFF_MODE2: rd_val = s_r.mode2;
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // Next state: synchronisers, bus slave, cell registers
    always_comb begin
        s_nxt = s_r;
        // Two flops before any logic; rc_prev only marks edges
        s_nxt.rc_meta = row_clk_i;
        s_nxt.rc_sync = s_r.rc_meta;
        s_nxt.rc_prev = s_r.rc_sync;
        s_nxt.q = q_v;
        // Ack one cycle after request, dropped the next cycle
        // Write lands as ack rises; the request still stands then
        s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
        if (s_nxt.ack && !wb_we_i) begin
            s_nxt.rdat = rd_val;
        end
        if (s_nxt.ack && wb_we_i) begin
            if (wb_adr_i[7:5] == `LCC_LUT_BASE_HI) begin
                s_nxt.lut[wb_adr_i[4:2]] = merge(s_r.lut[wb_adr_i[4:2]], wb_dat_i, wb_sel_i);
            end else begin
                unique case (wb_adr_i)
                    `LCC_OFF_CLKCFG: s_nxt.clkcfg = merge(s_r.clkcfg, wb_dat_i, wb_sel_i);
                    `LCC_OFF_MODE: s_nxt.mode = merge(s_r.mode, wb_dat_i, wb_sel_i);
                    `LCC_OFF_WIDE: s_nxt.wide = wb_sel_i[0] ? wb_dat_i[7:0] : s_r.wide;
                    `LCC_OFF_MODE2: s_nxt.mode2 = merge(s_r.mode2, wb_dat_i, wb_sel_i);
                    default: s_nxt.rdat = s_r.rdat;
                endcase
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Line two starts inverted on row 1 for falling-edge use
            s_r <= '{rc_meta: 6'h00, rc_sync: 6'h00, rc_prev: 6'h00,
                     clkcfg: `LCC_RST_CLKCFG, mode: `LCC_RST_MODE, mode2: `LCC_RST_MODE2,
                     wide: `LCC_RST_WIDE, lut: '0, q: 16'h0000, ack: 1'b0,
                     rdat: 32'h0000_0000};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; comb path is direct by design
    assign wb_dat_o = s_r.rdat;
    assign wb_ack_o = s_r.ack;
    // R12 R14 R18 route set shows lookup when bypassed
    assign route_o = (bypass & lut_v) | (~bypass & s_r.q);
    // R16 registered and unregistered results together
    assign lut_o = lut_v;
    assign reg_o = s_r.q;
    assign chain_o = s_r.q[15];

    // Cell register and clock line checks share one clock
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake, then clear, load, gating and clock edge checks
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_aclr_wins: assert property (|aclr_v |=> ((s_r.q & $past(aclr_v)) == 16'h0000)) // R20
        else $error("async clear lost");
    a_preset_high: assert property (|(aload_v & adat_v & ~aclr_v) // R7
        |=> ((s_r.q & $past(aload_v & adat_v & ~aclr_v)) == $past(aload_v & adat_v & ~aclr_v)))
        else $error("preset failed");
    a_gate_holds: assert property (~aclr_v[0] && ~aload_v[0] && ~edge_v[0] // R5
        |=> s_r.q[0] == $past(s_r.q[0])) else $error("gated register changed");
    a_sclr_first: assert property (edge_v[1] && sclr_i && !aclr_v[1] && !aload_v[1] // R20
        |=> !s_r.q[1]) else $error("sync clear failed");
    a_sload_data: assert property (edge_v[2] && sload_i && !sclr_i && !aclr_v[2] // R19
        && !aload_v[2] |=> s_r.q[2] == $past(adat_v[2])) else $error("sync load failed");
    a_chain_shift: assert property (edge_v[3] && s_r.mode2[3] && !sclr_i && !sload_i // R13
        && !aclr_v[3] && !aload_v[3] |=> s_r.q[3] == $past(s_r.q[2]))
        else $error("chain shift failed");
    a_ena0_gone: assert property (aload_use |-> line_gate[0]) // R6
        else $error("enable zero still gating");
    a_third_off: assert property (clk_conflict && s_r.mode[1:0] == 2'h2 |-> !edge_v[0]) // R3
        else $error("third clock source used");
    a_bypass_out: assert property (bypass[4] |-> route_o[4] == lut_o[4]) // R12
        else $error("bypass not combinational");
    a_rise_two: assert property ($rose(s_r.rc_prev[0]) |-> !line_rise[0] || // R21
        s_r.clkcfg[3]) else $error("edge seen twice");

    // Clock line selection and gating
    a_own_gate: assert property (edge_v[0] && s_r.mode[1:0] == 2'h1 // R4
        |-> clk_gate_i[1])
        else $error("line one edge without its enable");
    a_no_gate: assert property (!line_gate[0] && s_r.mode[1:0] == 2'h0 // R5
        |-> !edge_v[0])
        else $error("gated line zero produced an edge");
    a_row_edge: assert property ($rose(s_r.rc_sync[0]) && s_r.clkcfg[3:0] == 4'h0 // R21
        |-> line_rise[0])
        else $error("row rise not seen on line zero");
    // Load data, feedback and chain entry
    a_adat_f: assert property (edge_v[0] && sload_i && !sclr_i && !aclr_v[0] // R11
        && !aload_v[0] && s_r.clkcfg[`LCC_CLK_ADSEL_LSB]
        |=> s_r.q[0] == $past(data_i[5]))
        else $error("load data not taken from f input");
    a_feedback: assert property (s_r.mode[`LCC_MODE_FB_LSB] && !s_r.wide[0] // R15
        |-> lut_o[0] == s_r.lut[0][{data_i[3:1], s_r.q[0]}])
        else $error("register feedback not used by lookup");
    a_chain_in: assert property (edge_v[0] && s_r.mode2[0] && !sclr_i && !sload_i // R13
        && !aclr_v[0] && !aload_v[0] |=> s_r.q[0] == $past(chain_i))
        else $error("chain input not captured");
    a_aload_off: assert property (!aload_use |-> aload_v == 16'h0000) // R6
        else $error("async load active while unused");
    // Output sets and wide lookup
    a_route_reg: assert property (!bypass[5] |-> route_o[5] == reg_o[5]) // R12 R14
        else $error("route set lost register value");
    a_wide_half: assert property (s_r.wide[1] && !s_r.mode[`LCC_MODE_FB_LSB+1] // R17
        |-> lut_o[2] == lut_o[3])
        else $error("wide halves differ");

    c_chain: cover property (edge_v[3] && s_r.mode2[3]);
    c_preset: cover property (|(aload_v & adat_v));
    c_sload: cover property (edge_v[0] && sload_i);
    c_conflict: cover property (clk_conflict);
    c_wide: cover property (s_r.wide[0] && data_i[5]);

endmodule
`default_nettype wire

// file: test/lcc_fabric.sv
`timescale 1ns/100ps
`default_nettype none
// Row clock source standing in for the routing fabric
module lcc_fabric (
    // Clock and requests
    input wire logic clk_i,
    input wire logic [5:0] pulse_i,
    // Row clock lines
    output logic [5:0] row_clk_o
);
    logic [2:0] cnt [6] = '{default: 3'h0};
    // Four cycles high so the two-flop sync never misses a burst
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 6; k++) begin
            if (pulse_i[k]) begin
                cnt[k] <= 3'h4;
            end else if (cnt[k] != 3'h0) begin
                cnt[k] <= cnt[k] - 3'h1;
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            row_clk_o[k] = (cnt[k] != 3'h0);
        end
    end
endmodule
`default_nettype wire

// file: test/logic_cluster_control_and_cell_register_bench.sv
`timescale 1ns/100ps
`default_nettype none
module logic_cluster_control_and_cell_register_bench;
    localparam logic [31:0] LMASK = 32'h6996_AAAA;
    localparam logic [63:0] D1 = 64'h5A3C_96E1_0FF0_C3A5;
    localparam logic [63:0] D2 = 64'hA5C3_1E69_F00F_3C5A;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd;
    logic [5:0] pulse = 6'h00;
    logic [2:0] gate = 3'h7;
    logic [1:0] aclr = 2'h0;
    logic sclr = 1'b0;
    logic aload = 1'b0;
    logic sload = 1'b0;
    logic chain = 1'b0;
    logic [63:0] din = 64'h0;
    wire logic [31:0] rdat;
    wire logic ack;
    wire logic [5:0] row_clk;
    wire logic [15:0] route;
    wire logic [15:0] lut;
    wire logic [15:0] q;
    wire logic chain_q;
    int fails = 0;
    int cmp_count = 0;
    int cyc_n = 0;
    lcc_cluster dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .row_clk_i(row_clk), .clk_gate_i(gate),
        .aclr_i(aclr), .sclr_i(sclr), .aload_i(aload), .sload_i(sload),
        .data_i(din), .chain_i(chain), .route_o(route), .lut_o(lut), .reg_o(q),
        .chain_o(chain_q));
    lcc_fabric fab (.clk_i(clk_i), .pulse_i(pulse), .row_clk_o(row_clk));
    always #10 clk_i = ~clk_i;
    // Hang guard, well above the length of the sequence
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            fails++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Classic cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wdat <= d;
        we <= w;
        cyc <= 1'b1;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    // One row clock burst, then time for sync and capture
    task automatic tick(input logic [5:0] k);
        pulse <= k;
        @(posedge clk_i);
        pulse <= 6'h00;
        repeat (12) @(posedge clk_i);
    endtask
    function automatic logic [15:0] exp_lut(input logic [63:0] d);
        logic [15:0] r;
        for (int m = 0; m < 8; m++) begin
            r[2*m] = LMASK[d[8*m+:4]];
            r[2*m+1] = LMASK[16+d[8*m+:4]];
        end
        return r;
    endfunction
    function automatic logic [15:0] exp_e(input logic [63:0] d, input int s);
        logic [15:0] r;
        for (int m = 0; m < 8; m++) begin
            r[2*m] = d[8*m+4+s];
            r[2*m+1] = d[8*m+6+s];
        end
        return r;
    endfunction
    // Wide mode: f0 picks the mask for both halves
    function automatic logic [15:0] exp_wide(input logic [63:0] d);
        logic [15:0] r;
        for (int m = 0; m < 8; m++) begin
            r[2*m] = LMASK[(d[8*m+5] ? 16 : 0) + d[8*m+:4]];
            r[2*m+1] = r[2*m];
        end
        return r;
    endfunction
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset values, unmapped and read-only places
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000_0910);
        wb(1'b1, 8'h80, 32'hFFFF_FFFF);
        wb(1'b0, 8'h80, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h08, 32'hFFFF_FFFF);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        for (int m = 0; m < 8; m++) wb(1'b1, 8'h40 + 8'(4 * m), LMASK);
        din <= D1;
        @(posedge clk_i);
        chk(32'(lut), 32'(exp_lut(D1)));
        chk(32'(route), 32'h0);
        wb(1'b1, 8'h10, 32'hFFFF_0000);
        chk(32'(route), 32'(exp_lut(D1)));
        chk(32'(q), 32'h0);
        wb(1'b1, 8'h0C, 32'h0000_00FF);
        chk(32'(lut), 32'(exp_wide(D1)));
        wb(1'b1, 8'h0C, 32'h0);
        gate <= 3'b110;
        tick(6'h01);
        chk(32'(q), 32'h0);
        gate <= 3'b111;
        tick(6'h01);
        chk(32'(q), 32'(exp_lut(D1)));
        // modules on line one follow its own gate
        wb(1'b1, 8'h04, 32'h0000_5555);
        gate <= 3'b101;
        din <= D2;
        tick(6'h01);
        chk(32'(q), 32'(exp_lut(D1)));
        tick(6'h02);
        chk(32'(q), 32'(exp_lut(D1)));
        gate <= 3'b010;
        tick(6'h02);
        chk(32'(q), 32'(exp_lut(D2)));
        wb(1'b1, 8'h04, 32'h0);
        gate <= 3'b111;
        // sync load, then clear only on enabled edge
        sload <= 1'b1;
        tick(6'h01);
        chk(32'(q), 32'(exp_e(D2, 0)));
        sclr <= 1'b1;
        gate <= 3'b000;
        tick(6'h01);
        chk(32'(q), 32'(exp_e(D2, 0)));
        gate <= 3'b111;
        tick(6'h01);
        chk(32'(q), 32'h0);
        sclr <= 1'b0;
        // load data taken from the f inputs
        wb(1'b1, 8'h00, 32'hFFFF_0910);
        tick(6'h01);
        chk(32'(q), 32'(exp_e(D2, 1)));
        sload <= 1'b0;
        // preset through async load with data high
        wb(1'b1, 8'h00, 32'h0000_1910);
        din <= 64'hFFFF_FFFF_FFFF_FFFF;
        aload <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(32'(q), 32'h0000_FFFF);
        chk(32'(chain_q), 32'h1);
        aclr <= 2'b01;
        repeat (3) @(posedge clk_i);
        chk(32'(q), 32'h0);
        aclr <= 2'b00;
        aload <= 1'b0;
        // line zero runs even with its gate low
        gate <= 3'b000;
        din <= D1;
        tick(6'h01);
        chk(32'(q), 32'(exp_lut(D1)));
        gate <= 3'b111;
        wb(1'b1, 8'h00, 32'h0000_0910);
        // second clear line picked per module
        wb(1'b1, 8'h04, 32'hFF00_0000);
        aclr <= 2'b01;
        repeat (3) @(posedge clk_i);
        chk(32'(q), 32'(exp_lut(D1)));
        aclr <= 2'b10;
        repeat (3) @(posedge clk_i);
        chk(32'(q), 32'h0);
        aclr <= 2'b00;
        // register output stands in for input a
        wb(1'b1, 8'h04, 32'h00FF_0000);
        chk(32'(lut), 32'(exp_lut(D1 & 64'hFEFE_FEFE_FEFE_FEFE)));
        wb(1'b1, 8'h04, 32'h0);
        // chain shifts one place per edge
        wb(1'b1, 8'h10, 32'h0000_FFFF);
        chain <= 1'b1;
        tick(6'h01);
        chain <= 1'b0;
        tick(6'h01);
        chk(32'(q), 32'h0000_0002);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0000_0002);
        // three distinct rows shut line two off
        wb(1'b1, 8'h10, 32'h0);
        wb(1'b1, 8'h00, 32'h0000_0210);
        wb(1'b1, 8'h04, 32'h0000_0002);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0001_0002);
        tick(6'h04);
        chk(32'(q), 32'h0000_0002);
        give_verdict();
    end
endmodule
`default_nettype wire
